// ### power_up_config_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - programmed configuration memory bits cannot be changed again except by reset_i, which clears them
// - whole configuration memory is copied to control registers at every start
// - three ordered phases, enable to ready well under one millisecond
// - supply-ok flag rises once reference and supplies are good, gates sequence
// - active-low system reset held a few cycles after supply-ok, clearing registers
// - reset release raises configuration-transfer and enters phase two
// - phase two switches oscillator to the configured frequency
// - phase two gives each general pin its configured direction
// - host-bus mode turns pins 4 and 5 into serial data and clock
// - ready flag rises in phase three; serial acknowledge waits for it
// - always-on channels are enabled on entering phase three
// - pin-controlled channels enable at phase three only if their pin is high
// - channel enable comes from default, assigned pin or host command
// - device runs while enable pin high, disabled when it stays low over 100us
// - host soft-reset command restarts the device
// - control registers load from memory or host writes; status is read-only
// - start delay and ramp rate set per channel independently
// - pre-biased output keeps both gates off until reference exceeds output
// - soft-stop ramps down at set slope to set end level within target
// - each channel selects one of four switching phases
// - high and low gates never on together; dead time between them
// - standby regulator level 3.3V or 5V; on by enable, pin or host
// - enable low over 100us shuts down; shorter low pulses ignored
module power_up_config_sequencer
    import pwr_seq_pkg::*;
#(
    parameter int EN_LOW_LIMIT = pwr_seq_pkg::EN_LOW_CYCLES
) (
    // clock and reset
    input  wire logic                               ref_clk_i,
    input  wire logic                               reset_i,
    // power pins
    input  wire logic                               enable_pin_i,
    input  wire logic                               supply_good_i,
    // configuration memory programming
    input  wire logic                               otp_prog_i,
    input  wire logic [pwr_seq_pkg::AW-1:0]         otp_addr_i,
    input  wire logic [pwr_seq_pkg::DW-1:0]         otp_data_i,
    // host side of the serial interface
    input  wire logic                               host_restart_command_i,
    input  wire logic                               host_wr_i,
    input  wire logic [pwr_seq_pkg::AW-1:0]         host_addr_i,
    input  wire logic [pwr_seq_pkg::DW-1:0]         host_data_i,
    input  wire logic [pwr_seq_pkg::NCH-1:0]        channel_enable_host_bits_i,
    input  wire logic                               standby_host_on_i,
    input  wire logic                               serial_data_oe_i,
    // general pins
    input  wire logic [pwr_seq_pkg::NGPIO-1:0]      gpio_in_i,
    input  wire logic [pwr_seq_pkg::NGPIO-1:0]      gpio_out_data_i,
    output logic      [pwr_seq_pkg::NGPIO-1:0]      gpio_out_o,
    output logic      [pwr_seq_pkg::NGPIO-1:0]      gpio_oe_o,
    output logic                                    shared_pin_serial_data_o,
    output logic                                    shared_pin_serial_clock_o,
    // sequence status
    output logic                                    supply_ok_flag_o,
    output logic                                    system_reset_n_o,
    output logic                                    config_transfer_o,
    output logic                                    chip_ready_o,
    output logic                                    shutdown_o,
    output logic      [pwr_seq_pkg::FREQ_W-1:0]     osc_freq_sel_o,
    output logic                                    standby_regulator_output_o,
    output logic                                    standby_level_5v_o,
    // channels
    input  wire logic [pwr_seq_pkg::NCH-1:0]        pwm_i,
    input  wire logic [pwr_seq_pkg::NCH-1:0][7:0]   vout_sense_i,
    output logic      [pwr_seq_pkg::NCH-1:0]        gate_high_o,
    output logic      [pwr_seq_pkg::NCH-1:0]        gate_low_o,
    output logic      [pwr_seq_pkg::NCH-1:0]        channel_enabled_o,
    output logic      [pwr_seq_pkg::NCH-1:0][7:0]   ref_level_o,
    output logic      [pwr_seq_pkg::NCH-1:0][1:0]   phase_sel_o,
    output logic      [pwr_seq_pkg::NCH-1:0]        soft_start_busy_o
);
    import pwr_seq_pkg::*;

    logic [DW-1:0]    otp_ff [MEM_WORDS];
    logic [DW-1:0]    cfg_ff [MEM_WORDS];
    logic [1:0]       en_sync_ff;
    logic [1:0]       sup_sync_ff;
    logic [NGPIO-1:0] gp_s1_ff;
    logic [NGPIO-1:0] gp_s2_ff;
    logic [15:0]      en_low_ff;
    seq_state_t       state_ff;
    seq_state_t       nxt_state;
    logic [CW-1:0]    seq_cnt_ff;
    logic             ready_d_ff;
    logic             ready_entry;
    logic             en_off;
    logic [NCH-1:0]   ch_en_ff;

    // pin synchronisers
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            en_sync_ff  <= 2'b00;
            sup_sync_ff <= 2'b00;
            gp_s1_ff    <= '0;
            gp_s2_ff    <= '0;
        end else begin
            en_sync_ff  <= {en_sync_ff[0], enable_pin_i};
            sup_sync_ff <= {sup_sync_ff[0], supply_good_i};
            gp_s1_ff    <= gpio_in_i;
            gp_s2_ff    <= gp_s1_ff;
        end
    end

    // enable-low filter, saturating
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            en_low_ff <= 16'h0000;
        end else if (en_sync_ff[1]) begin
            en_low_ff <= 16'h0000;
        end else if (!en_off) begin
            en_low_ff <= en_low_ff + 16'h0001;
        end
    end
    assign en_off = (32'(en_low_ff) >= EN_LOW_LIMIT);

    // one-time programmable memory: bits only ever set, except that reset_i clears all
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < MEM_WORDS; i++) begin
                otp_ff[i] <= CFG_RESET;
            end
        end else if (otp_prog_i && 32'(otp_addr_i) < MEM_WORDS) begin
            otp_ff[otp_addr_i] <= otp_ff[otp_addr_i] | otp_data_i;
        end
    end

    // sequencer next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SEQ_SHUTDOWN: begin
                if (en_sync_ff[1]) begin
                    nxt_state = SEQ_SUPPLY;
                end
            end
            SEQ_SUPPLY: begin
                if (sup_sync_ff[1]) begin
                    nxt_state = SEQ_RESET;
                end
            end
            SEQ_RESET: begin
                if (32'(seq_cnt_ff) == RESET_HOLD_CYCLES - 1) begin
                    nxt_state = SEQ_TRANSFER;
                end
            end
            SEQ_TRANSFER: begin
                if (32'(seq_cnt_ff) == MEM_WORDS - 1) begin
                    nxt_state = SEQ_READY;
                end
            end
            SEQ_READY: nxt_state = SEQ_READY;
            default:   nxt_state = SEQ_SHUTDOWN;
        endcase
        if (state_ff != SEQ_SHUTDOWN) begin
            if (en_off) begin
                nxt_state = SEQ_SHUTDOWN;
            end else if (host_restart_command_i) begin
                nxt_state = SEQ_SUPPLY;
            end
        end
    end

    // sequencer state and phase counter
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff   <= SEQ_SHUTDOWN;
            seq_cnt_ff <= CNT_ZERO;
            ready_d_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            ready_d_ff <= chip_ready_o;
            if (nxt_state != state_ff) begin
                seq_cnt_ff <= CNT_ZERO;
            end else begin
                seq_cnt_ff <= seq_cnt_ff + 12'h001;
            end
        end
    end

    // phase flags
    assign supply_ok_flag_o  = (state_ff == SEQ_RESET) || (state_ff == SEQ_TRANSFER)
                               || (state_ff == SEQ_READY);
    assign system_reset_n_o  = (state_ff != SEQ_RESET);
    assign config_transfer_o = (state_ff == SEQ_TRANSFER);
    assign chip_ready_o      = (state_ff == SEQ_READY);
    assign shutdown_o        = (state_ff == SEQ_SHUTDOWN);
    assign ready_entry       = chip_ready_o && !ready_d_ff;

    // control registers: cleared in reset phase, loaded in transfer, host writes when ready
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < MEM_WORDS; i++) begin
                cfg_ff[i] <= CFG_RESET;
            end
        end else if (state_ff == SEQ_RESET) begin
            for (int i = 0; i < MEM_WORDS; i++) begin
                cfg_ff[i] <= CFG_RESET;
            end
        end else if (state_ff == SEQ_TRANSFER) begin
            cfg_ff[seq_cnt_ff[AW-1:0]] <= otp_ff[seq_cnt_ff[AW-1:0]];
        end else if (chip_ready_o && host_wr_i && 32'(host_addr_i) < MEM_WORDS) begin
            cfg_ff[host_addr_i] <= host_data_i;
        end
    end

    // oscillator and standby regulator settings
    assign osc_freq_sel_o     = cfg_ff[W_MISC][MISC_FREQ_LSB +: FREQ_W];
    assign standby_level_5v_o = cfg_ff[W_MISC][MISC_STB5V_BIT];
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            standby_regulator_output_o <= 1'b0;
        end else begin
            standby_regulator_output_o <=
                (cfg_ff[W_MISC][MISC_STBEN_BIT] && en_sync_ff[1])
                || (cfg_ff[W_MISC][MISC_STBGP_BIT] && gp_s2_ff[cfg_ff[W_STBSEL][2:0]])
                || (cfg_ff[W_MISC][MISC_STBHO_BIT] && standby_host_on_i);
        end
    end

    // pin roles; in host mode the serial data pin only pulls low
    always_comb begin
        gpio_out_o = gpio_out_data_i;
        gpio_oe_o  = cfg_ff[W_GDIR][NGPIO-1:0];
        if (cfg_ff[W_MISC][MISC_HOST_BIT]) begin
            gpio_out_o[SDA_PIN] = 1'b0;
            gpio_oe_o[SDA_PIN]  = serial_data_oe_i;
            gpio_oe_o[SCL_PIN]  = 1'b0;
        end
    end
    assign shared_pin_serial_data_o  = cfg_ff[W_MISC][MISC_HOST_BIT] && gp_s2_ff[SDA_PIN];
    assign shared_pin_serial_clock_o = cfg_ff[W_MISC][MISC_HOST_BIT] && gp_s2_ff[SCL_PIN];

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic          always_on;
            logic          pin_ctl;
            logic          host_ctl;
            logic          pin_lvl;
            ch_state_t     st_ff;
            logic [7:0]    ref_ff;
            logic [CW-1:0] tick_ff;
            logic [CW-1:0] dly_lim;
            logic [CW-1:0] step_lim;
            logic [7:0]    target;
            logic [7:0]    stop_lvl;
            logic          bias_ok_ff;
            logic          drive;
            logic [1:0]    dead_ff;
            logic          want_hi;
            logic          want_lo;

            assign always_on = cfg_ff[W_CHMODE][c];
            assign pin_ctl   = cfg_ff[W_CHMODE][MODE_PIN_LSB + c];
            assign host_ctl  = cfg_ff[W_HOSTCTL][c];
            assign pin_lvl   = gp_s2_ff[cfg_ff[W_PINSEL][2*c +: 2]];
            assign target    = cfg_ff[W_TARGET + c];
            assign stop_lvl  = (cfg_ff[W_STOP + c] > target) ? target : cfg_ff[W_STOP + c];
            assign dly_lim   = CW'(32'(cfg_ff[W_TIMING + c][3:0]) * DELAY_UNIT_CYCLES);
            assign step_lim  = CW'((32'(cfg_ff[W_TIMING + c][7:4]) + 1) * RAMP_UNIT_CYCLES);
            assign phase_sel_o[c] = cfg_ff[W_PHASE][2*c +: 2];

            // channel enable source selection
            always_ff @(posedge ref_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    ch_en_ff[c] <= 1'b0;
                end else if (!chip_ready_o) begin
                    ch_en_ff[c] <= 1'b0;
                end else if (always_on) begin
                    ch_en_ff[c] <= 1'b1;
                end else if (pin_ctl) begin
                    ch_en_ff[c] <= pin_lvl;
                end else if (host_ctl && !ready_entry) begin
                    ch_en_ff[c] <= channel_enable_host_bits_i[c];
                end
            end

            // soft-start / soft-stop reference ramp
            always_ff @(posedge ref_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    st_ff   <= CH_OFF;
                    ref_ff  <= 8'h00;
                    tick_ff <= CNT_ZERO;
                end else begin
                    tick_ff <= tick_ff + 12'h001;
                    case (st_ff)
                        CH_OFF: begin
                            ref_ff  <= 8'h00;
                            tick_ff <= CNT_ZERO;
                            if (ch_en_ff[c]) begin
                                st_ff <= CH_DELAY;
                            end
                        end
                        CH_DELAY: begin
                            if (!ch_en_ff[c]) begin
                                st_ff <= CH_OFF;
                            end else if (tick_ff >= dly_lim) begin
                                st_ff   <= CH_RAMP;
                                tick_ff <= CNT_ZERO;
                            end
                        end
                        CH_RAMP: begin
                            if (!ch_en_ff[c]) begin
                                st_ff   <= CH_STOP;
                                tick_ff <= CNT_ZERO;
                            end else if (ref_ff >= target) begin
                                st_ff <= CH_ON;
                            end else if (tick_ff + 12'h001 >= step_lim) begin
                                ref_ff  <= ref_ff + 8'h01;
                                tick_ff <= CNT_ZERO;
                            end
                        end
                        CH_ON: begin
                            if (!ch_en_ff[c]) begin
                                st_ff   <= CH_STOP;
                                tick_ff <= CNT_ZERO;
                            end
                        end
                        CH_STOP: begin
                            if (ch_en_ff[c]) begin
                                st_ff <= CH_RAMP;
                            end else if (ref_ff <= stop_lvl) begin
                                st_ff <= CH_OFF;
                            end else if (tick_ff + 12'h001 >= step_lim) begin
                                ref_ff  <= ref_ff - 8'h01;
                                tick_ff <= CNT_ZERO;
                            end
                        end
                        default: st_ff <= CH_OFF;
                    endcase
                end
            end

            // pre-bias hold: gates stay off until reference passes the output
            always_ff @(posedge ref_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    bias_ok_ff <= 1'b0;
                end else if (st_ff == CH_OFF || st_ff == CH_DELAY) begin
                    bias_ok_ff <= 1'b0;
                end else if (ref_ff > vout_sense_i[c]) begin
                    bias_ok_ff <= 1'b1;
                end
            end

            assign drive   = bias_ok_ff && (st_ff != CH_OFF) && (st_ff != CH_DELAY);
            assign want_hi = drive && pwm_i[c];
            assign want_lo = drive && !pwm_i[c];

            // gate driver with break-before-make dead time
            always_ff @(posedge ref_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    gate_high_o[c] <= 1'b0;
                    gate_low_o[c]  <= 1'b0;
                    dead_ff        <= 2'b00;
                end else if (gate_high_o[c] != want_hi || gate_low_o[c] != want_lo) begin
                    if (gate_high_o[c] || gate_low_o[c]) begin
                        gate_high_o[c] <= 1'b0;
                        gate_low_o[c]  <= 1'b0;
                        dead_ff        <= 2'(DEAD_CYCLES);
                    end else if (dead_ff == 2'b00) begin
                        gate_high_o[c] <= want_hi;
                        gate_low_o[c]  <= want_lo;
                    end else begin
                        dead_ff <= dead_ff - 2'b01;
                    end
                end else if (dead_ff != 2'b00) begin
                    dead_ff <= dead_ff - 2'b01;
                end
            end

            assign ref_level_o[c]       = ref_ff;
            assign channel_enabled_o[c] = ch_en_ff[c];
            assign soft_start_busy_o[c] = (st_ff == CH_DELAY) || (st_ff == CH_RAMP);
        end
    endgenerate
endmodule

// ### pwr_seq_pkg.sv
package pwr_seq_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS     = 10;
    localparam int EN_LOW_TIME_NS    = 100000;
    localparam int EN_LOW_CYCLES     = EN_LOW_TIME_NS / CLK_PERIOD_NS;
    localparam int DEAD_TIME_NS      = 20;
    localparam int DEAD_CYCLES       = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_UNIT_NS     = 1000;
    localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_NS / CLK_PERIOD_NS;
    localparam int RAMP_UNIT_NS      = 100;
    localparam int RAMP_UNIT_CYCLES  = RAMP_UNIT_NS / CLK_PERIOD_NS;
    localparam int RESET_HOLD_CYCLES = 4;
    // sizes
    localparam int NCH       = 4;
    localparam int NGPIO     = 6;
    localparam int MEM_WORDS = 20;
    localparam int AW        = 5;
    localparam int DW        = 8;
    localparam int CW        = 12;
    // configuration word map
    localparam int W_MISC    = 0;
    localparam int W_GDIR    = 1;
    localparam int W_CHMODE  = 2;
    localparam int W_PINSEL  = 3;
    localparam int W_PHASE   = 4;
    localparam int W_STBSEL  = 5;
    localparam int W_HOSTCTL = 6;
    localparam int W_TIMING  = 8;
    localparam int W_STOP    = 12;
    localparam int W_TARGET  = 16;
    // misc word fields, channel-mode pin field, serial pin numbers and reset constants
    localparam int MISC_FREQ_LSB  = 0;
    localparam int FREQ_W         = 3;
    localparam int MISC_HOST_BIT  = 3;
    localparam int MISC_STB5V_BIT = 4;
    localparam int MISC_STBEN_BIT = 5;
    localparam int MISC_STBGP_BIT = 6;
    localparam int MISC_STBHO_BIT = 7;
    localparam int MODE_PIN_LSB   = 4;
    localparam int SDA_PIN        = 4;
    localparam int SCL_PIN        = 5;
    localparam logic [DW-1:0] CFG_RESET = 8'h00;
    localparam logic [CW-1:0] CNT_ZERO  = 12'h000;

    typedef enum logic [2:0] {
        SEQ_SHUTDOWN = 3'b000,
        SEQ_SUPPLY   = 3'b001,
        SEQ_RESET    = 3'b010,
        SEQ_TRANSFER = 3'b011,
        SEQ_READY    = 3'b100
    } seq_state_t;

    typedef enum logic [2:0] {
        CH_OFF   = 3'b000,
        CH_DELAY = 3'b001,
        CH_RAMP  = 3'b010,
        CH_ON    = 3'b011,
        CH_STOP  = 3'b100
    } ch_state_t;
endpackage

// ### pwr_seq_properties.sv
`timescale 1ns/1ps
module pwr_seq_props
    import pwr_seq_pkg::*;
#(
    parameter int EN_LOW_LIMIT = pwr_seq_pkg::EN_LOW_CYCLES
) (
    // clock and reset
    input wire logic              ref_clk_i,
    input wire logic              reset_i,
    // watched inputs
    input wire logic              enable_pin_i,
    input wire logic              host_restart_command_i,
    input wire logic              host_wr_i,
    // watched status
    input wire logic              supply_ok_flag_o,
    input wire logic              system_reset_n_o,
    input wire logic              config_transfer_o,
    input wire logic              chip_ready_o,
    input wire logic              shutdown_o,
    input wire logic [FREQ_W-1:0] osc_freq_sel_o,
    input wire logic [NCH-1:0]    gate_high_o,
    input wire logic [NCH-1:0]    gate_low_o
);
    int   low_cnt_ff;
    logic wr_ok;
    // consecutive low cycles on the raw enable pin
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            low_cnt_ff <= 0;
        end else begin
            low_cnt_ff <= enable_pin_i ? 0 : low_cnt_ff + 1;
        end
    end
    assign wr_ok = host_wr_i && chip_ready_o;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence hold_reset; (!system_reset_n_o) [*4] ##1 system_reset_n_o; endsequence
    sequence load_then_ready; ##19 config_transfer_o ##1 chip_ready_o; endsequence
    a_reset_hold_four: assert property (
        $fell(system_reset_n_o) |-> hold_reset) else $error("reset hold length wrong");
    a_transfer_follows: assert property (
        $rose(system_reset_n_o) && supply_ok_flag_o |-> config_transfer_o) else $error("no transfer after reset");
    a_transfer_then_ready: assert property (
        $rose(config_transfer_o) |-> load_then_ready) else $error("transfer length or ready wrong");
    a_ready_needs_supply: assert property (
        chip_ready_o |-> supply_ok_flag_o && system_reset_n_o && !config_transfer_o && !shutdown_o)
        else $error("ready without supply ok");
    a_freq_change_cause: assert property (
        !$stable(osc_freq_sel_o) |-> $past(config_transfer_o) || $past(!system_reset_n_o) || $past(wr_ok)
        || $past(wr_ok, 2)) else $error("frequency changed without cause");
    a_long_low_off: assert property (
        low_cnt_ff == EN_LOW_LIMIT + 5 |-> shutdown_o) else $error("long enable low ignored");
    a_short_low_kept: assert property (
        $rose(shutdown_o) |-> low_cnt_ff >= EN_LOW_LIMIT) else $error("shutdown on short low");
    a_restart_drops_ready: assert property (
        chip_ready_o && host_restart_command_i |=> !chip_ready_o) else $error("ready kept after restart");
    a_gates_apart: assert property (
        (gate_high_o & gate_low_o) == 4'h0) else $error("both gates on");
    a_dead_gap: assert property (
        $fell(gate_high_o[0]) |-> (!gate_low_o[0]) [*3]) else $error("dead time too short");
endmodule
bind power_up_config_sequencer pwr_seq_props #(.EN_LOW_LIMIT(EN_LOW_LIMIT)) i_props (.*);

// ### host_model.sv
`timescale 1ns/1ps
module host_model
    import pwr_seq_pkg::*;
(
    // clock and device status
    input  wire logic           ref_clk_i,
    input  wire logic           chip_ready_o,
    // requests toward the device
    output logic                host_restart_command_i,
    output logic                host_wr_i,
    output logic [AW-1:0]       host_addr_i,
    output logic [DW-1:0]       host_data_i,
    output logic [NCH-1:0]      channel_enable_host_bits_i,
    output logic                standby_host_on_i
);
    // idle bus at time zero
    initial begin
        {host_restart_command_i, host_wr_i, host_addr_i, host_data_i} = '0;
        {channel_enable_host_bits_i, standby_host_on_i} = '0;
    end
    // write one word; no acknowledge before ready, so wait for it
    task automatic write_word(input logic [AW-1:0] a, input logic [DW-1:0] d);
        for (int i = 0; i < 1000 && chip_ready_o !== 1'b1; i++) @(negedge ref_clk_i);
        host_addr_i = a;
        host_data_i = d;
        host_wr_i = 1'b1;
        @(negedge ref_clk_i);
        host_wr_i = 1'b0;
        host_addr_i = ~a;
        @(negedge ref_clk_i);
    endtask
    // host enable bits for the channels, held as a level
    task automatic set_bits(input logic [NCH-1:0] b);
        channel_enable_host_bits_i = b;
    endtask
    // soft-reset command, one cycle
    task automatic restart();
        host_restart_command_i = 1'b1;
        @(negedge ref_clk_i);
        host_restart_command_i = 1'b0;
        @(negedge ref_clk_i);
    endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch at %0t got %h expected %h", $time, g, e); end end
module tb;
    import pwr_seq_pkg::*;
    localparam int LOW_LIM = 20;
    logic ref_clk_i = 0, reset_i = 1, enable_pin_i = 0, supply_good_i = 0, otp_prog_i = 0, serial_data_oe_i = 0;
    logic [AW-1:0] otp_addr_i = '0, host_addr_i;
    logic [DW-1:0] otp_data_i = '0, host_data_i;
    logic [NGPIO-1:0] gpio_in_i = 6'h22, gpio_out_data_i = 6'h11, gpio_out_o, gpio_oe_o;
    logic [NCH-1:0] pwm_i = 4'h0, gate_high_o, gate_low_o, channel_enabled_o, soft_start_busy_o;
    logic [NCH-1:0] channel_enable_host_bits_i;
    logic [NCH-1:0][7:0] vout_sense_i = {8'h00, 8'h00, 8'hff, 8'h00}, ref_level_o;
    logic [NCH-1:0][1:0] phase_sel_o;
    logic [FREQ_W-1:0] osc_freq_sel_o;
    logic host_restart_command_i, host_wr_i, standby_host_on_i, shared_pin_serial_data_o, shared_pin_serial_clock_o;
    logic supply_ok_flag_o, system_reset_n_o, config_transfer_o, chip_ready_o, shutdown_o;
    logic standby_regulator_output_o, standby_level_5v_o;
    logic [1:0] seen;
    logic [12:0] tbl [11] = '{13'h001d, 13'h0101, 13'h0261, 13'h0324, 13'h04e4, 13'h0608, 13'h0801,
                              13'h0b00, 13'h0f03, 13'h1010, 13'h1308};
    int miscompares = 0, num_checks = 0, n;
    power_up_config_sequencer #(.EN_LOW_LIMIT(LOW_LIM)) i_dut (.*);
    host_model i_host (.*);
    always #5 ref_clk_i = ~ref_clk_i;
    task automatic tick(input int k);
        repeat (k) @(negedge ref_clk_i);
    endtask
    task automatic wait_ready();
        for (n = 0; n < 99999 && chip_ready_o !== 1'b1; n++) tick(1);
    endtask
    task automatic otp_burn(input logic [AW-1:0] a, input logic [DW-1:0] d);
        otp_addr_i = a;
        otp_data_i = d;
        otp_prog_i = 1'b1;
        tick(1);
        otp_prog_i = 1'b0;
        tick(1);
    endtask
    task automatic t_power_up();
        foreach (tbl[i]) otp_burn(tbl[i][12:8], tbl[i][7:0]);
        enable_pin_i = 1'b1;
        supply_good_i = 1'b1;
        wait_ready();
        // two sync stages, one step to supply, one to reset hold, then hold and transfer
        `CHK(n, 4 + RESET_HOLD_CYCLES + MEM_WORDS)
        `CHK(osc_freq_sel_o, 3'h5)
        `CHK(gpio_oe_o[1:0], 2'b01)
        `CHK({gpio_out_o, shared_pin_serial_data_o, shared_pin_serial_clock_o}, 8'h05)
        `CHK(phase_sel_o, 8'he4)
        `CHK({standby_level_5v_o, standby_regulator_output_o}, 2'b10)
        tick(2);
        `CHK(channel_enabled_o, 4'h3)
    endtask
    task automatic t_host_ctrl();
        i_host.set_bits(4'h8);
        i_host.write_word(5'h00, 8'h22);
        tick(3);
        `CHK(channel_enabled_o[3], 1'b1)
        `CHK(osc_freq_sel_o, 3'h2)
        `CHK({gpio_out_o, shared_pin_serial_data_o, shared_pin_serial_clock_o}, 8'h44)
        `CHK({standby_level_5v_o, standby_regulator_output_o}, 2'b01)
    endtask
    task automatic t_ramp();
        seen = 2'b00;
        for (n = 0; n < 1000 && ref_level_o[0] !== 8'h10; n++) begin
            pwm_i = n[3] ? 4'hf : 4'h0;
            seen = seen | {gate_high_o[0], gate_high_o[1] | gate_low_o[1]};
            tick(1);
        end
        `CHK(ref_level_o[0], 8'h10)
        `CHK(ref_level_o[3], 8'h08)
        `CHK(soft_start_busy_o, 4'h1)
        `CHK(seen, 2'b10)
    endtask
    task automatic t_soft_stop();
        logic [7:0] lo;
        lo = 8'hff;
        i_host.set_bits(4'h0);
        for (n = 0; n < 1000 && (n < 5 || ref_level_o[3] !== 8'h00); n++) begin
            if (ref_level_o[3] != 8'h00 && ref_level_o[3] < lo) lo = ref_level_o[3];
            tick(1);
        end
        `CHK(lo, 8'h03)
        `CHK(channel_enabled_o[3], 1'b0)
    endtask
    task automatic t_restart();
        otp_burn(5'h00, 8'h02);
        otp_burn(5'h00, 8'h00);
        i_host.restart();
        `CHK(chip_ready_o, 1'b0)
        wait_ready();
        `CHK(osc_freq_sel_o, 3'h7)
    endtask
    task automatic t_enable();
        enable_pin_i = 1'b0;
        tick(LOW_LIM / 2);
        enable_pin_i = 1'b1;
        tick(30);
        `CHK({shutdown_o, chip_ready_o}, 2'b01)
        enable_pin_i = 1'b0;
        tick(2 * LOW_LIM);
        `CHK({shutdown_o, chip_ready_o}, 2'b10)
        enable_pin_i = 1'b1;
        wait_ready();
        `CHK(chip_ready_o, 1'b1)
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // main sequence
    initial begin
        tick(20);
        reset_i = 1'b0;
        t_power_up();
        t_host_ctrl();
        t_ramp();
        t_soft_stop();
        t_restart();
        t_enable();
        tally_and_finish();
    end
    // watchdog, far beyond the expected few hundred cycles
    initial begin
        #200us;
        miscompares++;
        tally_and_finish();
    end
endmodule
